/* design/omsel_top.sv */
// Purpose: Operation mode selector with APB register access
// Assumes: Single clock pclk at 100 MHz, asynchronous active-low reset
// Notes:   Terminal inputs pass a two-stage synchroniser first
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module omsel_top
	import omsel_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              pclk_en,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              panel_interlock_in,
	input  wire logic              output_stop_in,
	input  wire logic              panel_external_switch_in,
	input  wire logic              panel_network_switch_in,
	input  wire logic              external_network_switch_in,
	input  wire logic              forward_start_in,
	input  wire logic              reverse_start_in,
	input  wire logic              ext_freq_cmd_in,
	input  wire logic              alarm_in,
	input  wire logic              panel_stop_key_in,
	output omsel_mode_t            op_mode,
	output logic                   output_stop,
	output logic                   run_forward,
	output logic                   run_reverse,
	output logic                   drive_reset,
	output logic                   param_write_enable,
	output logic                   mode_ready
);

	omsel_state_t  q;
	omsel_state_t  d;
	omsel_term_t   t;
	omsel_term_t   t_raw;
	omsel_res_in_t ri;
	omsel_mode_t   res_mode;
	omsel_mode_t   mode_next;
	omsel_mode_t   init_mode;
	logic          res_refused;
	logic          panel_block;
	logic          ilk_src;
	logic          ilk_on;
	logic          stop_is_ilk;
	logic          stop_req;
	logic          start_any;
	logic          stopped;
	logic          ext_src;
	logic          go_fwd;
	logic          go_rev;
	logic          setup;
	logic          wr_access;
	logic          addr_err;

	assign t_raw = '{ilk: panel_interlock_in, stop: output_stop_in, pext: panel_external_switch_in,
		pnet: panel_network_switch_in, enet: external_network_switch_in, fwd: forward_start_in,
		rev: reverse_start_in, freq: ext_freq_cmd_in, alarm: alarm_in, key: panel_stop_key_in};

	// Every decision below looks only at this one registered sample
	omsel_sync #(
		.WIDTH    (TERM_W)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.pclk_en  (pclk_en),
		.async_in (t_raw),
		.sync_out (t)
	);

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return a == OFS_SELECT || a == OFS_CONFIG || a == OFS_COMMAND || a == OFS_STATUS;
	endfunction

	function automatic logic [DATA_W-1:0] rd_word(input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] w;
		w = '0;
		case (a)
			OFS_SELECT: begin
				w[SEL_W-1:0] = q.selector;
			end
			OFS_CONFIG: begin
				w[CFG_LOGIC_LSB +: 2]   = q.cfg.stop_logic;
				w[CFG_STARTUP_LSB +: 4] = q.cfg.startup;
				w[CFG_ILK_BIT]          = q.cfg.ilk_asg;
				w[CFG_PEXT_BIT]         = q.cfg.pext_asg;
				w[CFG_PNET_BIT]         = q.cfg.pnet_asg;
				w[CFG_ENET_BIT]         = q.cfg.enet_asg;
			end
			OFS_COMMAND: begin
				w[CMD_MODE_LSB +: MODE_W] = q.req_mode;
				w[CMD_REQ_BIT]            = q.req_valid;
				w[CMD_FWD_BIT]            = q.sw_fwd;
				w[CMD_REV_BIT]            = q.sw_rev;
			end
			OFS_STATUS: begin
				w[ST_MODE_LSB +: MODE_W] = q.mode;
				w[ST_ILK_BIT]            = ilk_on;
				w[ST_STOP_BIT]           = q.out_stop;
				w[ST_RUN_BIT]            = q.run_fwd | q.run_rev;
				w[ST_REFUSED_BIT]        = q.refused;
				w[ST_READY_BIT]          = q.phase == PH_ACTIVE;
			end
			default: begin
				w = '0;
			end
		endcase
		return w;
	endfunction

	// Interlock source and polarity
	assign ilk_src    = q.cfg.ilk_asg ? t.ilk
		: ((q.cfg.stop_logic == STOP_LOGIC_INV) ? !t.stop : t.stop);
	assign ilk_on     = (q.selector == SEL_INTERLOCK) ? ilk_src : 1'b1;
	assign stop_is_ilk = q.selector == SEL_INTERLOCK && !q.cfg.ilk_asg;
	// Output-stop role returns the moment the selector leaves 7
	assign stop_req   = (!stop_is_ilk && t.stop)
		|| (q.selector == SEL_INTERLOCK && ilk_on && q.mode == MODE_EXT);

	assign start_any  = t.fwd | t.rev;
	assign stopped    = !start_any && !q.run_fwd && !q.run_rev;

	assign init_mode  = ((q.cfg.startup == STARTUP_NET_A || q.cfg.startup == STARTUP_NET_B)
		&& omsel_sw_pnet(q.selector)) ? MODE_NET : MODE_EXT;

	assign ri = '{selector: q.selector, ilk_on: ilk_on,
		can_change: stopped || q.selector == SEL_SWITCHOVER || q.phase == PH_INIT,
		term: t, cfg: q.cfg, cur: (q.phase == PH_INIT) ? init_mode : q.mode,
		req_valid: q.req_valid, req_mode: q.req_mode};

	omsel_resolve u_resolve (
		.ri        (ri),
		.next_mode (res_mode),
		.refused   (res_refused)
	);

	// Panel mode may not be entered with a start command present, except under selector 1 or in the init phase
	assign panel_block = res_mode == MODE_PANEL && q.mode != MODE_PANEL && start_any
		&& q.selector != SEL_PANEL_FIXED && q.phase == PH_ACTIVE;
	assign mode_next   = panel_block ? q.mode : res_mode;

	// Terminals drive direction in external and combined-1 modes
	assign ext_src = q.mode == MODE_EXT || q.mode == MODE_COMB1;
	assign go_fwd  = q.phase == PH_ACTIVE && !stop_req && !t.alarm
		&& (ext_src ? (t.fwd && !t.rev && (t.freq || q.mode == MODE_COMB1))
		: (q.sw_fwd && !q.sw_rev));
	assign go_rev  = q.phase == PH_ACTIVE && !stop_req && !t.alarm
		&& (ext_src ? (t.rev && !t.fwd && (t.freq || q.mode == MODE_COMB1))
		: (q.sw_rev && !q.sw_fwd));

	assign setup     = psel && !penable && pclk_en;
	assign wr_access = psel && penable && pwrite && pclk_en;
	assign addr_err  = !mapped(paddr) || (pwrite && paddr == OFS_CONFIG && !ilk_on);

	always_comb begin
		d = q;
		if (pclk_en) begin
			d.phase       = PH_ACTIVE;
			d.mode        = mode_next;
			d.out_stop    = stop_req;
			d.run_fwd     = go_fwd;
			d.run_rev     = go_rev;
			d.key_prev    = t.key;
			d.drive_reset = t.alarm && t.key && !q.key_prev;
			d.req_valid   = 1'b0;
			if (setup) begin
				d.prdata = pwrite ? '0 : rd_word(paddr);
				d.err    = addr_err;
			end
			if (wr_access && !q.err) begin
				case (paddr)
					OFS_SELECT: begin
						d.selector = pwdata[SEL_W-1:0];
					end
					OFS_CONFIG: begin
						d.cfg.stop_logic = pwdata[CFG_LOGIC_LSB +: 2];
						d.cfg.startup    = pwdata[CFG_STARTUP_LSB +: 4];
						d.cfg.ilk_asg    = pwdata[CFG_ILK_BIT];
						d.cfg.pext_asg   = pwdata[CFG_PEXT_BIT];
						d.cfg.pnet_asg   = pwdata[CFG_PNET_BIT];
						d.cfg.enet_asg   = pwdata[CFG_ENET_BIT];
					end
					OFS_COMMAND: begin
						d.sw_fwd = pwdata[CMD_FWD_BIT];
						d.sw_rev = pwdata[CMD_REV_BIT];
						if (pwdata[CMD_REQ_BIT]) begin
							d.req_valid = 1'b1;
							d.req_mode  = omsel_mode_t'(pwdata[CMD_MODE_LSB +: MODE_W]);
						end
					end
					OFS_STATUS: begin
						if (pwdata[ST_REFUSED_BIT]) begin
							d.refused = 1'b0;
						end
					end
					default: begin
						d.err = q.err;
					end
				endcase
			end
			// A refusal in the clearing cycle still lands
			if (res_refused || panel_block) begin
				d.refused = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= OMSEL_STATE_RST;
		end else begin
			q <= d;
		end
	end

	assign prdata             = q.prdata;
	assign pready             = pclk_en;
	assign pslverr            = psel && penable && q.err;
	assign op_mode            = q.mode;
	assign output_stop        = q.out_stop;
	assign run_forward        = q.run_fwd;
	assign run_reverse        = q.run_rev;
	assign drive_reset        = q.drive_reset;
	assign param_write_enable = ilk_on;
	assign mode_ready         = q.phase == PH_ACTIVE;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_ilk_forced;
		q.selector == SEL_INTERLOCK && !ilk_on && pclk_en && q.phase == PH_ACTIVE;
	endsequence

	sequence s_key_press;
		t.alarm && t.key && !q.key_prev && pclk_en;
	endsequence

	chk_forced_external: assert property (s_ilk_forced |=> q.mode == MODE_EXT)
		else $error("interlock off did not force external mode");

	chk_external_run: assert property (q.phase == PH_ACTIVE && q.mode == MODE_EXT && t.fwd && !t.rev && t.freq
		&& !stop_req && !t.alarm && pclk_en |=> run_forward)
		else $error("external start with frequency did not run");

	chk_hold_external: assert property (s_ilk_forced ##1 (!ilk_on && q.selector == SEL_INTERLOCK && pclk_en)
		|=> q.mode == MODE_EXT && !$changed(q.mode))
		else $error("mode left external while interlock off");

	chk_ilk_stop: assert property (q.selector == SEL_INTERLOCK && ilk_on && q.mode == MODE_EXT && pclk_en
		|=> output_stop)
		else $error("interlock on in external mode did not stop output");

	chk_no_panel_start: assert property (q.phase == PH_ACTIVE && q.mode != MODE_PANEL && start_any
		&& q.selector != SEL_PANEL_FIXED && pclk_en |=> op_mode != MODE_PANEL)
		else $error("panel mode entered with a start command");

	chk_stop_role: assert property (q.selector != SEL_INTERLOCK && t.stop && pclk_en |=> output_stop)
		else $error("output-stop input ignored outside selector 7");

	chk_ilk_polarity: assert property (q.selector == SEL_INTERLOCK && !q.cfg.ilk_asg
		&& q.cfg.stop_logic == STOP_LOGIC_INV && t.stop && q.phase == PH_ACTIVE && pclk_en
		|=> op_mode == MODE_EXT)
		else $error("interlock polarity wrong under inverted logic");

	chk_reset_key: assert property (s_key_press |=> drive_reset ##1 (!drive_reset || !pclk_en || t.key))
		else $error("stop key on alarm did not pulse drive reset");

	chk_fixed_modes: assert property (q.selector == SEL_PANEL_FIXED && pclk_en |=> op_mode == MODE_PANEL)
		else $error("selector 1 did not fix panel mode");

	chk_switch_ignored: assert property (q.selector == SEL_COMB1 && pclk_en
		&& $changed(t.pext) |=> op_mode == MODE_COMB1)
		else $error("switch acted outside selectors 0, 6 and 7");

	chk_run_hold: assert property (q.selector == SEL_EXT_PANEL && q.phase == PH_ACTIVE && !stopped && pclk_en
		|=> $stable(q.mode))
		else $error("mode changed during operation");

	chk_switch_sense: assert property (q.selector == SEL_EXT_PANEL && q.cfg.pext_asg && !q.cfg.pnet_asg
		&& !q.cfg.enet_asg && stopped && q.phase == PH_ACTIVE && t.pext && pclk_en
		|=> op_mode == MODE_EXT)
		else $error("switch on did not select external mode");

	chk_write_block: assert property (setup && pwrite && paddr == OFS_CONFIG && !ilk_on
		##1 (psel && penable) |-> pslverr)
		else $error("parameter write accepted while interlock off");

	chk_no_early_run: assert property (q.phase == PH_INIT |=> !run_forward && !run_reverse)
		else $error("run granted before mode evaluation");

endmodule
`default_nettype wire

/* design/omsel_pkg.sv */
// Purpose: Shared constants and types for the operation mode selector
// Assumes: APB register slave, 32-bit data, one aligned word per register
// Notes:   Mode codes and register fields used by all omsel modules
package omsel_pkg;

	localparam int unsigned ADDR_W      = 8;
	localparam int unsigned DATA_W      = 32;
	localparam int unsigned SEL_W       = 4;
	localparam int unsigned MODE_W      = 3;
	localparam int unsigned TERM_W      = 10;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_SELECT  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CONFIG  = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_COMMAND = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h0c;

	// Mode selector values
	localparam logic [SEL_W-1:0] SEL_EXT_PANEL   = 4'h0;
	localparam logic [SEL_W-1:0] SEL_PANEL_FIXED = 4'h1;
	localparam logic [SEL_W-1:0] SEL_EXT_FIXED   = 4'h2;
	localparam logic [SEL_W-1:0] SEL_COMB1       = 4'h3;
	localparam logic [SEL_W-1:0] SEL_COMB2       = 4'h4;
	localparam logic [SEL_W-1:0] SEL_SWITCHOVER  = 4'h6;
	localparam logic [SEL_W-1:0] SEL_INTERLOCK   = 4'h7;
	localparam logic [SEL_W-1:0] SEL_RESET       = SEL_EXT_PANEL;

	localparam logic [1:0]       STOP_LOGIC_INV  = 2'h2;
	localparam logic [3:0]       STARTUP_NET_A   = 4'h1;
	localparam logic [3:0]       STARTUP_NET_B   = 4'ha;

	// Field positions
	localparam int unsigned CFG_LOGIC_LSB   = 0;
	localparam int unsigned CFG_STARTUP_LSB = 4;
	localparam int unsigned CFG_ILK_BIT     = 8;
	localparam int unsigned CFG_PEXT_BIT    = 9;
	localparam int unsigned CFG_PNET_BIT    = 10;
	localparam int unsigned CFG_ENET_BIT    = 11;
	localparam int unsigned CMD_MODE_LSB    = 0;
	localparam int unsigned CMD_REQ_BIT     = 3;
	localparam int unsigned CMD_FWD_BIT     = 4;
	localparam int unsigned CMD_REV_BIT     = 5;
	localparam int unsigned ST_MODE_LSB     = 0;
	localparam int unsigned ST_ILK_BIT      = 3;
	localparam int unsigned ST_STOP_BIT     = 4;
	localparam int unsigned ST_RUN_BIT      = 5;
	localparam int unsigned ST_REFUSED_BIT  = 6;
	localparam int unsigned ST_READY_BIT    = 7;

	typedef enum logic [MODE_W-1:0] {
		MODE_EXT   = 3'b000,
		MODE_PANEL = 3'b001,
		MODE_NET   = 3'b010,
		MODE_COMB1 = 3'b011,
		MODE_COMB2 = 3'b100
	} omsel_mode_t;

	typedef enum logic {
		PH_INIT   = 1'b0,
		PH_ACTIVE = 1'b1
	} omsel_phase_t;

	typedef struct packed {
		logic ilk;
		logic stop;
		logic pext;
		logic pnet;
		logic enet;
		logic fwd;
		logic rev;
		logic freq;
		logic alarm;
		logic key;
	} omsel_term_t;

	typedef struct packed {
		logic [1:0] stop_logic;
		logic [3:0] startup;
		logic       ilk_asg;
		logic       pext_asg;
		logic       pnet_asg;
		logic       enet_asg;
	} omsel_cfg_t;

	typedef struct packed {
		logic [SEL_W-1:0] selector;
		logic             ilk_on;
		logic             can_change;
		omsel_term_t      term;
		omsel_cfg_t       cfg;
		omsel_mode_t      cur;
		logic             req_valid;
		omsel_mode_t      req_mode;
	} omsel_res_in_t;

	typedef struct packed {
		omsel_phase_t     phase;
		omsel_mode_t      mode;
		logic [SEL_W-1:0] selector;
		omsel_cfg_t       cfg;
		logic             req_valid;
		omsel_mode_t      req_mode;
		logic             sw_fwd;
		logic             sw_rev;
		logic             run_fwd;
		logic             run_rev;
		logic             out_stop;
		logic             drive_reset;
		logic             key_prev;
		logic             refused;
		logic [DATA_W-1:0] prdata;
		logic             err;
	} omsel_state_t;

	localparam omsel_state_t OMSEL_STATE_RST = '{phase: PH_INIT, mode: MODE_EXT, selector: SEL_RESET,
		req_mode: MODE_EXT, default: '0};

	function automatic logic omsel_sw_pext(input logic [SEL_W-1:0] sel);
		return sel == SEL_EXT_PANEL || sel == SEL_SWITCHOVER || sel == SEL_INTERLOCK;
	endfunction

	function automatic logic omsel_sw_pnet(input logic [SEL_W-1:0] sel);
		return sel == SEL_EXT_PANEL || sel == SEL_SWITCHOVER;
	endfunction

	function automatic logic omsel_sw_enet(input logic [SEL_W-1:0] sel);
		return omsel_sw_pext(sel) || sel == SEL_EXT_FIXED;
	endfunction

endpackage

/* design/omsel_sync.sv */
// Purpose: Two-stage synchroniser for the control terminal inputs
// Assumes: Inputs may change at any time relative to pclk
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none
module omsel_sync
	import omsel_pkg::*;
#(
	parameter int unsigned WIDTH = TERM_W
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             pclk_en,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} omsel_sync_st_t;

	omsel_sync_st_t q;
	omsel_sync_st_t d;

	always_comb begin
		d = q;
		if (pclk_en) begin
			d.s1 = async_in;
			d.s2 = q.s1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_out = q.s2;

endmodule
`default_nettype wire

/* design/omsel_resolve.sv */
// Purpose: Combinational choice of the next operation mode
// Assumes: All inputs are registered, sampled values
// Notes:   Order of checks gives the switching priority
`timescale 1ns/1ps
`default_nettype none
module omsel_resolve
	import omsel_pkg::*;
(
	input  wire omsel_res_in_t ri,
	output omsel_mode_t        next_mode,
	output logic               refused
);

	logic pext_act;
	logic pnet_act;
	logic enet_act;
	logic req_ok;

	assign pext_act = ri.cfg.pext_asg && omsel_sw_pext(ri.selector);
	assign pnet_act = ri.cfg.pnet_asg && omsel_sw_pnet(ri.selector);
	assign enet_act = ri.cfg.enet_asg && omsel_sw_enet(ri.selector);
	assign req_ok   = (ri.req_mode == MODE_EXT || ri.req_mode == MODE_NET || ri.req_mode == MODE_PANEL)
		&& !(ri.selector == SEL_EXT_FIXED && ri.req_mode == MODE_PANEL);

	always_comb begin
		next_mode = ri.cur;
		refused   = 1'b0;
		case (ri.selector)
			SEL_PANEL_FIXED: begin
				next_mode = MODE_PANEL;
				refused   = ri.req_valid;
			end
			SEL_COMB1: begin
				next_mode = MODE_COMB1;
				refused   = ri.req_valid;
			end
			SEL_COMB2: begin
				next_mode = MODE_COMB2;
				refused   = ri.req_valid;
			end
			SEL_EXT_PANEL, SEL_EXT_FIXED, SEL_SWITCHOVER, SEL_INTERLOCK: begin
				if (!ri.ilk_on) begin
					next_mode = MODE_EXT;
					refused   = ri.req_valid && ri.req_mode != MODE_EXT;
				end else if (!ri.can_change) begin
					refused   = ri.req_valid;
				end else if (enet_act && ri.term.enet) begin
					next_mode = MODE_NET;
				end else if (pnet_act) begin
					next_mode = ri.term.pnet ? MODE_PANEL : (enet_act ? MODE_EXT : MODE_NET);
				end else if (pext_act) begin
					next_mode = ri.term.pext ? MODE_EXT : MODE_PANEL;
				end else if (enet_act) begin
					next_mode = MODE_EXT;
				end else if (ri.req_valid) begin
					if (req_ok) begin
						next_mode = ri.req_mode;
					end else begin
						refused   = 1'b1;
					end
				end else if (ri.selector == SEL_EXT_FIXED && ri.cur != MODE_NET) begin
					next_mode = MODE_EXT;
				end
			end
			default: begin
				refused   = ri.req_valid;
			end
		endcase
	end

endmodule
`default_nettype wire

/* tb/omsel_term_model.sv */
// Purpose: Behavioural control terminals and operator panel keys
// Assumes: Bench sets wanted levels just after a clock edge
// Notes:   Contacts settle one edge late, like real relays
`timescale 1ns/1ps
`default_nettype none
module omsel_term_model
	import omsel_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire omsel_term_t want,
	output var  omsel_term_t pins
);
	// Switch levels only mean something once the terminal is assigned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins <= '0;
		end else begin
			pins <= want;
		end
	end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the operation mode selector
// Assumes: pclk_en tied high, so every access has zero wait
// Notes:   Terminal changes are given six edges to pass the synchroniser
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import omsel_pkg::*;
;
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata;
	logic [DATA_W-1:0] prdata;
	logic              pready;
	logic              pslverr;
	omsel_term_t       tv;
	omsel_term_t       want;
	omsel_term_t       pins;
	omsel_mode_t       op_mode;
	logic              output_stop;
	logic              run_forward;
	logic              run_reverse;
	logic              drive_reset;
	logic              param_write_enable;
	logic              mode_ready;
	int                err_total;
	int                n_tests;
	int                k;
	logic [SEL_W-1:0]  sw_sel [3] = '{SEL_EXT_PANEL, SEL_SWITCHOVER, SEL_INTERLOCK};
	logic [SEL_W-1:0]  fx_sel [4] = '{SEL_PANEL_FIXED, SEL_EXT_FIXED, SEL_COMB1, SEL_COMB2};
	omsel_mode_t       fx_mode [4] = '{MODE_PANEL, MODE_EXT, MODE_COMB1, MODE_COMB2};

	omsel_term_model u_term (.pclk, .presetn, .want, .pins);

	omsel_top DUT (
		.pclk, .presetn, .pclk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr,
		.panel_interlock_in(pins.ilk), .output_stop_in(pins.stop),
		.panel_external_switch_in(pins.pext), .panel_network_switch_in(pins.pnet),
		.external_network_switch_in(pins.enet), .forward_start_in(pins.fwd),
		.reverse_start_in(pins.rev), .ext_freq_cmd_in(pins.freq), .alarm_in(pins.alarm),
		.panel_stop_key_in(pins.key), .op_mode, .output_stop, .run_forward,
		.run_reverse, .drive_reset, .param_write_enable, .mode_ready
	);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic end_sim();
		$display("errors %0d of %0d checks", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chm(input omsel_mode_t e);
		chk({29'h0, op_mode}, {29'h0, e});
	endtask

	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] r, output logic e);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1) begin
			err_total++;
			end_sim();
		end
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic ee);
		logic [DATA_W-1:0] r;
		logic              e;
		apb(1'b1, a, d, r, e);
		chk({31'h0, e}, {31'h0, ee});
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
		input logic [DATA_W-1:0] m, input logic ee);
		logic [DATA_W-1:0] r;
		logic              e;
		apb(1'b0, a, '0, r, e);
		chk(r & m, exp);
		chk({31'h0, e}, {31'h0, ee});
	endtask

	// Pin to output takes 4 edges; 6 leaves margin without hiding a stuck path
	task automatic settle();
		repeat (6) @(posedge pclk);
	endtask

	task automatic put();
		@(posedge pclk);
		want <= tv;
		settle();
	endtask

	task automatic pulses(input int exp);
		int n;
		@(posedge pclk);
		want <= tv;
		n = 0;
		repeat (10) begin
			@(posedge pclk);
			if (drive_reset === 1'b1) n++;
		end
		chk(n, exp);
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		end_sim();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		tv = '0;
		want = '0;
		err_total = 0;
		n_tests = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk({31'h0, mode_ready}, 32'h0000_0001);
		chm(MODE_EXT);
		rd(OFS_SELECT, 32'h0000_0000, 32'hffff_ffff, 1'b0);
		rd(OFS_STATUS, 32'h0000_0080, 32'h0000_0087, 1'b0);
		rd(8'h10, 32'h0000_0000, 32'hffff_ffff, 1'b1);
		wr(OFS_CONFIG, 32'h0000_0200, 1'b0);
		// Stop terminal high keeps the interlock on under selector 7
		tv.stop = 1'b1;
		foreach (sw_sel[i]) begin
			wr(OFS_SELECT, {28'h0, sw_sel[i]}, 1'b0);
			for (k = 0; k < 2; k++) begin
				tv.pext = k[0];
				put();
				chm(k[0] ? MODE_EXT : MODE_PANEL);
			end
		end
		tv.stop = 1'b0;
		foreach (fx_sel[i]) begin
			wr(OFS_SELECT, {28'h0, fx_sel[i]}, 1'b0);
			tv.pext = (i == 0);
			put();
			chm(fx_mode[i]);
		end
		wr(OFS_CONFIG, 32'h0000_0a00, 1'b0);
		wr(OFS_SELECT, 32'h0000_0002, 1'b0);
		tv.enet = 1'b1;
		put();
		chm(MODE_NET);
		tv.pext = 1'b1;
		wr(OFS_SELECT, 32'h0000_0000, 1'b0);
		settle();
		chm(MODE_NET);
		wr(OFS_SELECT, 32'h0000_0001, 1'b0);
		settle();
		chm(MODE_PANEL);
		wr(OFS_SELECT, 32'h0000_0000, 1'b0);
		tv.enet = 1'b0;
		tv.pext = 1'b0;
		put();
		chm(MODE_PANEL);
		wr(OFS_COMMAND, 32'h0000_0010, 1'b0);
		settle();
		chk({30'h0, run_reverse, run_forward}, 32'h0000_0001);
		tv.pext = 1'b1;
		put();
		chm(MODE_PANEL);
		wr(OFS_SELECT, 32'h0000_0006, 1'b0);
		settle();
		chm(MODE_EXT);
		wr(OFS_COMMAND, 32'h0000_0000, 1'b0);
		wr(OFS_SELECT, 32'h0000_0000, 1'b0);
		tv.fwd = 1'b1;
		tv.pext = 1'b0;
		put();
		chm(MODE_EXT);
		tv.fwd = 1'b0;
		put();
		chm(MODE_PANEL);
		// No dedicated interlock terminal: stop input takes the role
		wr(OFS_SELECT, 32'h0000_0007, 1'b0);
		tv.stop = 1'b1;
		put();
		chm(MODE_PANEL);
		tv.stop = 1'b0;
		put();
		chm(MODE_EXT);
		chk({31'h0, param_write_enable}, 32'h0000_0000);
		wr(OFS_CONFIG, 32'h0000_0200, 1'b1);
		wr(OFS_SELECT, 32'h0000_0007, 1'b0);
		wr(OFS_COMMAND, 32'h0000_0009, 1'b0);
		settle();
		chm(MODE_EXT);
		tv.fwd = 1'b1;
		tv.freq = 1'b1;
		put();
		chk({30'h0, run_reverse, run_forward}, 32'h0000_0001);
		tv.stop = 1'b1;
		put();
		chk({31'h0, output_stop}, 32'h0000_0001);
		chm(MODE_EXT);
		tv.stop = 1'b0;
		put();
		chk({30'h0, output_stop, run_forward}, 32'h0000_0001);
		// Reverse start under forced external mode
		tv.fwd = 1'b0;
		tv.rev = 1'b1;
		put();
		chk({30'h0, run_reverse, run_forward}, 32'h0000_0002);
		tv.rev = 1'b0;
		tv.fwd = 1'b0;
		tv.freq = 1'b0;
		tv.stop = 1'b1;
		put();
		wr(OFS_CONFIG, 32'h0000_0202, 1'b0);
		settle();
		chk({31'h0, param_write_enable}, 32'h0000_0000);
		tv.stop = 1'b0;
		put();
		chk({31'h0, param_write_enable}, 32'h0000_0001);
		chm(MODE_PANEL);
		wr(OFS_SELECT, 32'h0000_0000, 1'b0);
		tv.stop = 1'b1;
		put();
		chk({31'h0, output_stop}, 32'h0000_0001);
		wr(OFS_SELECT, 32'h0000_0007, 1'b0);
		settle();
		chk({31'h0, param_write_enable}, 32'h0000_0000);
		rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0007, 1'b0);
		tv = '0;
		tv.alarm = 1'b1;
		put();
		tv.key = 1'b1;
		pulses(1);
		tv = '0;
		put();
		tv.key = 1'b1;
		pulses(0);
		end_sim();
	end
endmodule
`default_nettype wire
